/* dca_dual_dma.sv */
// Two cascaded four-channel DMA controllers with an AHB-Lite slave
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// RQ1: Controller one, indices 000 to 00F, runs the 8-bit channels.
// RQ2: Controller two, indices 0C0 to 0DE, runs the 16-bit channels.
// RQ3: Controller two channel 0 carries controller one's bus ownership.
// RQ4: Mode code: demand 00, single 01, block 10, cascade 11.
// RQ5: Demand mode transfers while request holds, releases and resumes.
// RQ6: Demand and block step address and count like single mode.
// RQ7: Single mode: one transfer per request, count down, address steps.
// RQ8: Terminal count when the count wraps from zero to all ones.
// RQ9: Peripheral holds its request until acknowledge arrives.
// RQ10: A held single request gives one transfer; bus released between.
// RQ11: Block mode runs from one request straight to terminal count.
// RQ12: Software uses block mode sparingly; refresh is locked out.
// RQ13: Cascade grants the bus while requested, ignoring address and count.
// RQ14: A cascaded bus master makes its own read and write strobes.
// RQ15: Address outputs float whenever the master indication is high.
// RQ16: Type code: verify 00, write 01, read 10.
// RQ17: Verify transfers assert no read or write strobe.
// RQ18: Autoinitialize reloads address and count at terminal count.
// RQ19: Fixed or rotating priority; controller two outranks controller one. Code ranks controller one, as channel 4, above channels 5-7 when fixed.
// RQ20: Read strobe two clocks, write one; extended write matches read.
// RQ21: Mask disables; set by terminal count unless auto, reset, clear.
// RQ22: Terminal count flags clear on reset, master clear, status read.
// RQ23: Acknowledge only for the granted channel, dropped when service ends.
// RQ24: Terminal count indication driven during the final transfer.
module dca_dual_dma #(
  parameter int BUS_DIV = dca_pkg::BUS_DIV
) (
  input  logic        sys_clk,
  input  logic        reset,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic [31:0] hrdata,
  output logic        hreadyout,
  output logic        hresp,
  input  logic [3:0]  drqLow,
  input  logic [3:1]  drqHigh,
  input  logic        masterIn,
  output logic [7:0]  dackOut,
  output logic [15:0] busAddr,
  output logic        busAddrOe,
  output logic        ioRead,
  output logic        ioWrite,
  output logic        memRead,
  output logic        memWrite,
  output logic        tcOut,
  output logic        wideXfer
);
  localparam int DW = $clog2(BUS_DIV);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_STEP,
    ST_CASCADE
  } dca_state_t;

  dca_state_t  state_q;
  logic [2:0]  own_q;
  logic [1:0]  phase_q;
  logic [DW-1:0] divCnt_q;
  logic        tick;
  logic [7:0]  pinM_q;
  logic [7:0]  pin2_q;
  logic [7:0]  pin3_q;
  logic [7:0]  pinS_q;
  logic [7:0]  drqAll;
  logic        masterS;
  logic [7:0]  mask_q;
  logic [7:0]  req_q;
  logic [7:0]  tc_q;
  logic [7:0]  holdOff_q;
  logic [2:0]  cmd_q [2];
  logic [5:0]  mode_q [8];
  logic [1:0]  last_q [2];
  logic [3:0]  c1Req;
  logic [3:0]  c2Req;
  logic        c1Any;
  logic [2:0]  p1;
  logic [2:0]  p2;
  logic        grantValid;
  logic [2:0]  grantCh;
  logic [15:0] curAddr [8];
  logic [15:0] curCount [8];
  logic [7:0]  atTerm;
  logic        atTermOwn;
  logic        contRq;
  logic        goOn;
  logic        stepPulse;
  logic        owning;
  logic        inStrobe;
  logic        wrOn;
  logic [1:0]  wrLen;
  dca_pkg::dca_xmode_t ownMode;
  dca_pkg::dca_xmode_t grantMode;
  dca_pkg::dca_xtype_t ownType;
  logic        ownAuto;
  logic        accept;
  logic [9:0]  idx;
  logic [9:0]  off2;
  logic        hiZero;
  logic        hit1;
  logic        hit2;
  logic        aOk;
  logic [3:0]  aReg;
  logic [2:0]  rdCh;
  logic [15:0] rdVal;
  logic [1:0]  rdClr;
  logic        wrPend_q;
  logic        wrCtl_q;
  logic [3:0]  wrReg_q;
  logic [2:0]  wSel;
  logic [2:0]  wBase;
  logic [1:0]  mclr;
  logic [31:0] hrdata_q;
  logic [7:0]  dack_q;
  logic [15:0] busAddr_q;
  logic        busAddrOe_q;
  logic        tcOut_q;
  logic        wideXfer_q;
  logic        ioRead_q;
  logic        ioWrite_q;
  logic        memRead_q;
  logic        memWrite_q;

  // Lowest-offset request wins, starting at channel 0, or after the last served channel when rotating
  function automatic logic [2:0] pick(
    input logic [3:0] r,
    input logic       rot,
    input logic [1:0] last
  );
    logic [1:0] k;
    logic [2:0] res;
    res = 3'h0;
    for (int j = 3; j >= 0; j--)
    begin
      k = (rot ? last + 2'h1 : 2'h0) + 2'(j);
      if (r[k])
        res = {1'b1, k};
    end
    return res;
  endfunction

  // Bus clock enable; all transfer timing counts these ticks
  always_ff @(posedge sys_clk)
  begin
    if (reset || tick)
      divCnt_q <= '0;
    else
      divCnt_q <= divCnt_q + DW'(1);
  end
  assign tick = (divCnt_q == DW'(BUS_DIV - 1));

  // Three-stage pin synchroniser; a change needs stages two and three
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pinM_q <= 8'h00;
      pin2_q <= 8'h00;
      pin3_q <= 8'h00;
      pinS_q <= 8'h00;
    end
    else
    begin
      pinM_q <= {masterIn, drqHigh, drqLow};
      pin2_q <= pinM_q;
      pin3_q <= pin2_q;
      pinS_q <= (pin2_q & pin3_q) | (pinS_q & (pin2_q | pin3_q));
    end
  end
  assign masterS = pinS_q[7];

  // Controller one asks for the bus through controller two channel 0
  assign c1Req = {4{~cmd_q[0][dca_pkg::CF_DIS]}}
               & ((pinS_q[3:0] & ~mask_q[3:0] & ~holdOff_q[3:0])
                  | req_q[3:0]);
  assign c1Any = |c1Req; // RQ3
  assign drqAll = {pinS_q[6:4], c1Any, pinS_q[3:0]};
  assign c2Req = {4{~cmd_q[1][dca_pkg::CF_DIS]}}
               & ((drqAll[7:4] & ~mask_q[7:4] & ~holdOff_q[7:4])
                  | {req_q[7:5], 1'b0});

  // Controller two first; its channel 0 hands over to controller one
  assign p1 = pick(c1Req, cmd_q[0][dca_pkg::CF_ROT], last_q[0]); // RQ19
  assign p2 = pick(c2Req, cmd_q[1][dca_pkg::CF_ROT], last_q[1]); // RQ19
  assign grantValid = p2[2]; // RQ19
  assign grantCh = (p2[1:0] == 2'h0) ? {1'b0, p1[1:0]}
                                     : {1'b1, p2[1:0]}; // RQ3

  // Owner's mode fields
  assign ownMode = dca_pkg::dca_xmode_t'(mode_q[own_q][dca_pkg::MD_MODE+:2]);
  assign ownType = dca_pkg::dca_xtype_t'(mode_q[own_q][dca_pkg::MD_TYPE+:2]);
  assign ownAuto = mode_q[own_q][dca_pkg::MD_AUTO];
  assign grantMode =
    dca_pkg::dca_xmode_t'(mode_q[grantCh][dca_pkg::MD_MODE+:2]);
  assign atTermOwn = atTerm[own_q];
  assign contRq = drqAll[own_q] | req_q[own_q];
  assign stepPulse = (state_q == ST_STEP);
  assign owning = (state_q == ST_SETUP) || (state_q == ST_STROBE)
               || stepPulse;

  // Block runs to the end; demand runs while requested
  assign goOn = !atTermOwn
             && ((ownMode == dca_pkg::XM_BLOCK) // RQ11
                 || ((ownMode == dca_pkg::XM_DEMAND) && contRq)); // RQ5

  // Transfer sequencer, paced by bus clock ticks
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      own_q   <= 3'h0;
      phase_q <= 2'h0;
    end
    else
      case (state_q)
        ST_IDLE:
          if (tick && grantValid)
          begin
            own_q <= grantCh;
            if (grantMode == dca_pkg::XM_CASCADE)
              state_q <= ST_CASCADE; // RQ13
            else
              state_q <= ST_SETUP; // RQ4
          end
        ST_SETUP:
          if (tick)
          begin
            state_q <= ST_STROBE;
            phase_q <= 2'h0;
          end
        ST_STROBE:
          if (tick)
          begin
            if (phase_q == 2'(dca_pkg::READ_TICKS - 1))
              state_q <= ST_STEP;
            else
              phase_q <= phase_q + 2'h1;
          end
        ST_STEP:
          // Single mode always falls back to idle, freeing the bus
          state_q <= goOn ? ST_SETUP : ST_IDLE; // RQ10
        ST_CASCADE:
          if (tick && !contRq)
            state_q <= ST_IDLE; // RQ13
        default:
          state_q <= ST_IDLE;
      endcase
  end

  // Rotating priority remembers the last served channel
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      last_q[0] <= 2'h3;
      last_q[1] <= 2'h3;
    end
    else if (state_q == ST_IDLE && tick && grantValid)
    begin
      last_q[grantCh[2]] <= grantCh[1:0]; // RQ19
      if (!grantCh[2])
        last_q[1] <= 2'h0; // RQ19
    end
  end

  // Eight channels of counters
  for (genvar i = 0; i < 8; i++)
  begin : g_ch
    dca_channel u_ch (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .ldAddr     (wrPend_q && !wrReg_q[3] && !wrReg_q[0]
                   && ({wrCtl_q, wrReg_q[2:1]} == 3'(i))),
      .ldCount    (wrPend_q && !wrReg_q[3] && wrReg_q[0]
                   && ({wrCtl_q, wrReg_q[2:1]} == 3'(i))),
      .wdata      (hwdata[15:0]),
      .step       (stepPulse && (own_q == 3'(i))), // RQ6
      .decrement  (mode_q[i][dca_pkg::MD_DEC]),
      .autoInit   (mode_q[i][dca_pkg::MD_AUTO]),
      .curAddr    (curAddr[i]),
      .curCount   (curCount[i]),
      .atTerminal (atTerm[i])
    );
  end

  // Strobe timing: write strobe covers the tail of the read strobe
  assign wrLen = cmd_q[own_q[2]][dca_pkg::CF_EXTWR]
               ? 2'(dca_pkg::READ_TICKS) : 2'(dca_pkg::WRITE_TICKS); // RQ20
  assign inStrobe = (state_q == ST_STROBE);
  assign wrOn = inStrobe
             && (phase_q >= 2'(dca_pkg::READ_TICKS) - wrLen); // RQ20

  // Strobes by type; verify and illegal codes drive none
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ioRead_q   <= 1'b0;
      ioWrite_q  <= 1'b0;
      memRead_q  <= 1'b0;
      memWrite_q <= 1'b0;
    end
    else
    begin
      ioRead_q   <= inStrobe && (ownType == dca_pkg::XT_WRITE); // RQ16
      memWrite_q <= wrOn && (ownType == dca_pkg::XT_WRITE); // RQ16
      memRead_q  <= inStrobe && (ownType == dca_pkg::XT_READ); // RQ17
      ioWrite_q  <= wrOn && (ownType == dca_pkg::XT_READ); // RQ17
    end
  end

  // Acknowledge, address and terminal count toward the bus
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      dack_q      <= 8'h00;
      busAddr_q   <= 16'h0000;
      busAddrOe_q <= 1'b0;
      tcOut_q     <= 1'b0;
      wideXfer_q  <= 1'b0;
    end
    else
    begin
      if (state_q == ST_IDLE)
        dack_q <= 8'h00; // RQ23
      else
        dack_q <= (8'h01 << own_q) | {3'h0, !own_q[2], 4'h0}; // RQ23
      // Cascade leaves the address lines to the bus master
      busAddrOe_q <= owning && !masterS; // RQ15
      if (owning)
        busAddr_q <= curAddr[own_q];
      tcOut_q    <= owning && atTermOwn; // RQ24
      wideXfer_q <= own_q[2] && (state_q != ST_IDLE);
    end
  end

  // Address phase decode; unmapped or non-word accesses do nothing
  assign accept = hsel && hready && htrans[1];
  assign idx    = haddr[11:2];
  assign hiZero = (haddr[31:12] == 20'h00000);
  assign off2   = idx - dca_pkg::C2_FIRST;
  assign hit1   = hiZero && (idx <= dca_pkg::C1_LAST); // RQ1
  assign hit2   = hiZero && (idx >= dca_pkg::C2_FIRST)
               && (idx <= dca_pkg::C2_LAST) && !idx[0]; // RQ2
  assign aReg   = hit2 ? off2[4:1] : idx[3:0];
  assign aOk    = (hit1 || hit2) && (hsize == dca_pkg::HSIZE_WORD);
  assign rdCh   = {hit2, aReg[2:1]};

  // Read value: current counters or status
  always_comb
  begin
    rdVal = 16'h0000;
    if (!aReg[3])
      rdVal = aReg[0] ? curCount[rdCh] : curAddr[rdCh];
    else if (aReg == dca_pkg::R_STATCMD)
      rdVal = {8'h00, drqAll[{hit2, 2'h0}+:4], tc_q[{hit2, 2'h0}+:4]};
  end
  assign rdClr = {2{accept && !hwrite && aOk
                    && (aReg == dca_pkg::R_STATCMD)}}
               & {hit2, !hit2}; // RQ22

  // Read data registered at the address phase; writes wait for data
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      hrdata_q <= 32'h0;
      wrPend_q <= 1'b0;
      wrCtl_q  <= 1'b0;
      wrReg_q  <= 4'h0;
    end
    else if (accept)
    begin
      hrdata_q <= (!hwrite && aOk) ? {16'h0000, rdVal} : 32'h0;
      wrPend_q <= hwrite && aOk;
      wrCtl_q  <= hit2;
      wrReg_q  <= aReg;
    end
    else
      wrPend_q <= 1'b0;
  end

  assign wSel  = {wrCtl_q, hwdata[1:0]};
  assign wBase = {wrCtl_q, 2'h0};
  assign mclr  = {2{wrPend_q && (wrReg_q == dca_pkg::R_MCLR)}}
               & {wrCtl_q, !wrCtl_q};

  // Command and mode registers; clear pointer has no byte toggle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cmd_q[0] <= dca_pkg::CMD_RST;
      cmd_q[1] <= dca_pkg::CMD_RST;
      for (int i = 0; i < 8; i++)
        mode_q[i] <= dca_pkg::MODE_RST;
    end
    else
    begin
      if (mclr[0])
        cmd_q[0] <= dca_pkg::CMD_RST;
      if (mclr[1])
        cmd_q[1] <= dca_pkg::CMD_RST;
      if (wrPend_q && wrReg_q == dca_pkg::R_STATCMD)
        cmd_q[wrCtl_q] <= {hwdata[dca_pkg::CMD_EXTWR],
                           hwdata[dca_pkg::CMD_ROT],
                           hwdata[dca_pkg::CMD_DIS]};
      if (wrPend_q && wrReg_q == dca_pkg::R_MODE)
        mode_q[wSel] <= hwdata[dca_pkg::MODE_LSB+:6]; // RQ4
    end
  end

  // Mask bits; terminal count set is applied last so it wins
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      mask_q <= dca_pkg::MASK_RST; // RQ21
    else
    begin
      for (int c = 0; c < 2; c++)
        if (mclr[c])
          mask_q[c*4+:4] <= 4'hf; // RQ21
      if (wrPend_q && wrReg_q == dca_pkg::R_SMASK)
        mask_q[wSel] <= hwdata[dca_pkg::SEL_BIT];
      if (wrPend_q && wrReg_q == dca_pkg::R_CLRMASK)
        mask_q[wBase+:4] <= 4'h0;
      if (wrPend_q && wrReg_q == dca_pkg::R_MASKALL)
        mask_q[wBase+:4] <= hwdata[3:0];
      if (stepPulse && atTermOwn && !ownAuto)
        mask_q[own_q] <= 1'b1; // RQ21
    end
  end

  // Terminal count flags; a new count beats a same-cycle clear
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      tc_q <= 8'h00; // RQ22
    else
    begin
      for (int c = 0; c < 2; c++)
        if (mclr[c] || rdClr[c])
          tc_q[c*4+:4] <= 4'h0; // RQ22
      if (stepPulse && atTermOwn)
        tc_q[own_q] <= 1'b1; // RQ8
    end
  end

  // Software requests ignore the mask and end at terminal count
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      req_q <= 8'h00;
    else
    begin
      for (int c = 0; c < 2; c++)
        if (mclr[c])
          req_q[c*4+:4] <= 4'h0;
      if (wrPend_q && wrReg_q == dca_pkg::R_REQ)
        req_q[wSel] <= hwdata[dca_pkg::SEL_BIT];
      if (stepPulse && atTermOwn)
        req_q[own_q] <= 1'b0;
    end
  end

  // A held single-mode request must drop before it counts again
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      holdOff_q <= 8'h00;
    else
    begin
      holdOff_q <= holdOff_q & drqAll;
      if (stepPulse && ownMode == dca_pkg::XM_SINGLE)
        holdOff_q[own_q] <= 1'b1; // RQ10
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = dca_pkg::HRESP_OKAY;
  assign dackOut   = dack_q;
  assign busAddr   = busAddr_q;
  assign busAddrOe = busAddrOe_q;
  assign ioRead    = ioRead_q;
  assign ioWrite   = ioWrite_q;
  assign memRead   = memRead_q;
  assign memWrite  = memWrite_q;
  assign tcOut     = tcOut_q;
  assign wideXfer  = wideXfer_q;
endmodule

/* dca_pkg.sv */
// Constants and types shared by the dual cascaded DMA block
package dca_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [9:0] C1_FIRST = 10'h000;
  localparam logic [9:0] C1_LAST  = 10'h00f;
  localparam logic [9:0] C2_FIRST = 10'h0c0;
  localparam logic [9:0] C2_LAST  = 10'h0de;
  // Register numbers inside one controller
  localparam logic [3:0] R_STATCMD = 4'h8;
  localparam logic [3:0] R_REQ     = 4'h9;
  localparam logic [3:0] R_SMASK   = 4'ha;
  localparam logic [3:0] R_MODE    = 4'hb;
  localparam logic [3:0] R_CLRPTR  = 4'hc;
  localparam logic [3:0] R_MCLR    = 4'hd;
  localparam logic [3:0] R_CLRMASK = 4'he;
  localparam logic [3:0] R_MASKALL = 4'hf;
  // Command write bits and their stored positions
  localparam int CMD_EXTWR = 5;
  localparam int CMD_ROT   = 4;
  localparam int CMD_DIS   = 2;
  localparam int CF_EXTWR  = 2;
  localparam int CF_ROT    = 1;
  localparam int CF_DIS    = 0;
  // Set/clear bit of request and single mask writes
  localparam int SEL_BIT = 2;
  // Mode write keeps bits 7:2; stored field positions
  localparam int MODE_LSB = 2;
  localparam int MD_MODE  = 4;
  localparam int MD_DEC   = 3;
  localparam int MD_AUTO  = 2;
  localparam int MD_TYPE  = 0;
  // Transfer modes and types
  typedef enum logic [1:0] {
    XM_DEMAND  = 2'h0,
    XM_SINGLE  = 2'h1,
    XM_BLOCK   = 2'h2,
    XM_CASCADE = 2'h3
  } dca_xmode_t;
  typedef enum logic [1:0] {
    XT_VERIFY = 2'h0,
    XT_WRITE  = 2'h1,
    XT_READ   = 2'h2
  } dca_xtype_t;
  // Reset values
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [2:0] CMD_RST  = 3'h0;
  localparam logic [5:0] MODE_RST = 6'h00;
  // Timing: bus clock derived from the system clock
  localparam int SYS_CLK_NS  = 10;
  localparam int BUS_CLK_NS  = 125;
  localparam int BUS_DIV     = BUS_CLK_NS / SYS_CLK_NS;
  localparam int READ_TICKS  = 2;
  localparam int WRITE_TICKS = 1;
  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'b0;
endpackage

/* dca_channel.sv */
// One DMA channel: base and current address and word count
`timescale 1ns/1ns
module dca_channel (
  input  logic        sys_clk,
  input  logic        reset,
  input  logic        ldAddr,
  input  logic        ldCount,
  input  logic [15:0] wdata,
  input  logic        step,
  input  logic        decrement,
  input  logic        autoInit,
  output logic [15:0] curAddr,
  output logic [15:0] curCount,
  output logic        atTerminal
);
  logic [15:0] baseAddr_q;
  logic [15:0] baseCount_q;
  logic [15:0] curAddr_q;
  logic [15:0] curCount_q;

  // Base values kept for autoinitialize reload
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      baseAddr_q  <= 16'h0000;
      baseCount_q <= 16'h0000;
    end
    else
    begin
      if (ldAddr)
        baseAddr_q <= wdata;
      if (ldCount)
        baseCount_q <= wdata;
    end
  end

  // Current address follows base load, then steps per transfer
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      curAddr_q <= 16'h0000;
    else if (ldAddr)
      curAddr_q <= wdata;
    else if (step)
    begin
      if (atTerminal && autoInit)
        curAddr_q <= baseAddr_q; // RQ18
      else if (decrement)
        curAddr_q <= curAddr_q - 16'h0001; // RQ7
      else
        curAddr_q <= curAddr_q + 16'h0001; // RQ7
    end
  end

  // Count wraps from zero to all ones on the final transfer, unless autoinitialize reloads it
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      curCount_q <= 16'h0000;
    else if (ldCount)
      curCount_q <= wdata;
    else if (step)
    begin
      if (atTerminal && autoInit)
        curCount_q <= baseCount_q; // RQ18
      else
        curCount_q <= curCount_q - 16'h0001; // RQ7
    end
  end

  assign curAddr    = curAddr_q;
  assign curCount   = curCount_q;
  assign atTerminal = (curCount_q == 16'h0000); // RQ8
endmodule

/* dca_periph_model.sv */
// Stand-in for AT-bus peripherals and a cascaded bus master
`timescale 1ns/1ns
module dca_periph_model (
  input  logic       sys_clk,
  input  logic       reset,
  input  logic [7:0] req,
  input  logic [7:0] once,
  input  logic [7:0] casc,
  input  logic [7:0] dackOut,
  output logic [3:0] drqLow,
  output logic [3:1] drqHigh,
  output logic       masterIn
);
  logic [7:0] served_q;
  logic [7:0] drq;
  // A one-shot device lets go once acknowledged; a master flags ownership
  always_ff @(posedge sys_clk)
  begin
    served_q <= reset ? 8'h00 : req & (served_q | dackOut);
    masterIn <= !reset && |(dackOut & casc);
  end
  // Held until acknowledge, so no request is lost to the synchroniser
  assign drq     = req & ~(once & served_q);
  assign drqLow  = drq[3:0];
  assign drqHigh = drq[7:5];
endmodule

/* dca_dual_dma_assertions.sv */
// Port checker for the dual cascaded DMA block
`timescale 1ns/1ns
module dca_dual_dma_assertions #(
  parameter int BUS_DIV = 12
) (
  input logic       sys_clk,
  input logic       reset,
  input logic       hreadyout,
  input logic       hresp,
  input logic       masterIn,
  input logic [7:0] dackOut,
  input logic       busAddrOe,
  input logic       ioRead,
  input logic       ioWrite,
  input logic       memRead,
  input logic       memWrite,
  input logic       tcOut,
  input logic       wideXfer
);
  logic       rdOn;
  logic       wrOn;
  logic [7:0] rdLen_q;
  logic [7:0] wrLen_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  assign rdOn = ioRead | memRead;
  assign wrOn = ioWrite | memWrite;
  // Strobe run lengths, so pulse widths can be judged at the fall
  always_ff @(posedge sys_clk)
  begin
    rdLen_q <= (rdOn && !reset) ? rdLen_q + 8'h01 : 8'h00;
    wrLen_q <= (wrOn && !reset) ? wrLen_q + 8'h01 : 8'h00;
  end
  // Long enough for the indication to cross the synchroniser
  sequence masterHeld;
    masterIn [*5];
  endsequence
  ahb_okay_a: assert property (hreadyout && hresp == dca_pkg::HRESP_OKAY)
    else $error("slave not ready or not okay");
  ack_single_a: assert property ($onehot0(dackOut[3:0]) &&
    $onehot0(dackOut[7:5]) && !(dackOut[4] && |dackOut[7:5]))
    else $error("more than one acknowledge");
  cascade_ack_a: assert property (|dackOut[3:0] |-> dackOut[4] && !wideXfer)
    else $error("controller one owns bus without cascade grant");
  addr_float_a: assert property (masterHeld |-> !busAddrOe)
    else $error("address driven under bus master");
  strobe_owner_a: assert property (rdOn || wrOn |-> |dackOut)
    else $error("strobe without a granted channel");
  dir_pair_a: assert property (!(ioRead && memRead) && !(ioWrite && memWrite))
    else $error("both sides strobed in one direction");
  read_len_a: assert property ($fell(rdOn) |-> rdLen_q == 2 * BUS_DIV)
    else $error("read strobe width wrong");
  write_len_a: assert property ($fell(wrOn) |-> wrLen_q == BUS_DIV ||
    wrLen_q == 2 * BUS_DIV)
    else $error("write strobe width wrong");
  tc_final_a: assert property (tcOut |-> |dackOut)
    else $error("terminal count outside a transfer");
  wide_owner_a: assert property (wideXfer |-> |dackOut[7:5])
    else $error("wide transfer without a controller two channel");
endmodule
bind dca_dual_dma dca_dual_dma_assertions #(.BUS_DIV(BUS_DIV))
  dca_dual_dma_assertions_i (.*);

/* testbench.sv */
// Self-checking bench for the dual cascaded DMA block
`timescale 1ns/1ns
module testbench;
  localparam int DIV = 2;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = dca_pkg::HSIZE_WORD;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  req = 8'h00;
  logic [7:0]  once = 8'h00;
  logic [7:0]  casc = 8'h00;
  logic        hreadyout, hresp, masterIn, busAddrOe, tcOut, wideXfer;
  logic        ioRead, ioWrite, memRead, memWrite;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [3:0]  drqLow;
  logic [3:1]  drqHigh;
  logic [7:0]  dackOut;
  logic [15:0] busAddr;
  logic [2:0]  prev;
  int          errorCnt, nCompared, nMr, nMw, nAny, nTc, nX, xTc, a, n;
  int          mA[8], mC[8], bA[8], bC[8];
  dca_dual_dma #(.BUS_DIV(DIV)) dca_dual_dma_i (.hready(hreadyout), .*);
  dca_periph_model dca_periph_model_i (.*);
  always #5 sys_clk = ~sys_clk;
  // Strobe and terminal-count edges, and cycles with any strobe, seen from the bus side
  always @(posedge sys_clk)
  begin
    nMr  += int'(memRead & !prev[0]);
    nMw  += int'(memWrite & !prev[1]);
    nTc  += int'(tcOut & !prev[2]);
    nAny += int'(ioRead | ioWrite | memRead | memWrite);
    prev = {tcOut, memWrite, memRead};
  end
  task automatic test_done;
    $display("errors=%0d compared=%0d", errorCnt, nCompared);
    if (errorCnt == 0 && nCompared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail;
    errorCnt++;
    test_done();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nCompared++;
    if (g !== e)
    begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Ready is sampled at each edge; a hang ends the run
  task automatic rdy;
    int i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50)
      fail();
  endtask
  task automatic bus(input logic w, input int idx, input int wd);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= 32'(idx * 4);
    hwrite <= w;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= 32'(wd);
    rdy();
    rd = hrdata;
  endtask
  function automatic int ix(input int c, input int r);
    return c ? int'(dca_pkg::C2_FIRST) + 2 * r : r;
  endfunction
  task automatic rdChk(input int idx, input int e);
    bus(1'b0, idx, 0);
    chk(32'(rd[15:0]), 32'(e));
  endtask
  task automatic waitDack(input int k, input logic v);
    int i = 0;
    while (dackOut[k] !== v && i < 900)
    begin
      @(posedge sys_clk);
      i++;
    end
    if (i >= 900)
      fail();
  endtask
  // Program address, count and mode, then unmask the channel
  task automatic setup(input int c, ch, md, ty, dec, au, ad, cn);
    int k = c * 4 + ch;
    bus(1'b1, ix(c, 2 * ch), ad);
    bus(1'b1, ix(c, 2 * ch + 1), cn);
    bus(1'b1, ix(c, 11), md * 64 + dec * 32 + au * 16 + ty * 4 + ch);
    bus(1'b1, ix(c, 10), ch);
    mA[k] = ad;
    bA[k] = ad;
    mC[k] = cn;
    bC[k] = cn;
  endtask
  // Reference channel: one transfer steps address and count
  task automatic adv(input int k, input int dec, input int au);
    nX++;
    mA[k] = (mA[k] + (dec ? -1 : 1)) & 'hffff;
    mC[k] = (mC[k] - 1) & 'hffff;
    if (mC[k] == 'hffff)
    begin
      xTc++;
      mA[k] = au ? bA[k] : mA[k];
      mC[k] = au ? bC[k] : mC[k];
    end
  endtask
  // Request until served, then make sure the grant does not come back
  task automatic serve(input int k);
    req[k] <= 1'b1;
    waitDack(k, 1'b1);
    waitDack(k, 1'b0);
    repeat (20) @(posedge sys_clk);
    chk(dackOut[k], 0);
    req[k] <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic clr;
    nMr = 0;
    nMw = 0;
    nAny = 0;
    nTc = 0;
    nX = 0;
    xTc = 0;
  endtask
  initial
  begin
    void'($urandom(32'h2ff4a695));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset state and refused accesses, then channel 4 set to cascade and controller two unmasked
    rdChk(ix(0, 8), 0);
    rdChk(ix(1, 8), 0);
    rdChk('h100, 0);
    rdChk('hc1, 0);
    bus(1'b1, ix(1, 11), 'hc0);
    bus(1'b1, ix(1, 14), 0);
    // Single write, request held: one transfer per request
    a = $urandom % 'h10000;
    setup(0, 1, 1, 1, 0, 0, a, 2);
    clr();
    repeat (3)
    begin
      serve(1);
      adv(1, 0, 0);
    end
    chk(nMw, nX);
    chk(nMr, 0);
    chk(nTc, xTc);
    chk(nAny, 2 * DIV * nX);
    chk(busAddr, mA[1] - 1 & 'hffff);
    rdChk(ix(0, 2), mA[1]);
    rdChk(ix(0, 3), mC[1]);
    rdChk(ix(0, 8), 'h02);
    rdChk(ix(0, 8), 0);
    req[1] <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk(dackOut, 0);
    req[1] <= 1'b0;
    // Block read from one brief request, decrementing, autoinitialized
    a = $urandom % 'h10000;
    n = 1 + $urandom % 3;
    setup(1, 2, 2, 2, 1, 1, a, n);
    once[6] <= 1'b1;
    clr();
    serve(6);
    repeat (n + 1) adv(6, 1, 1);
    chk(nMr, nX);
    chk(nMw, 0);
    rdChk(ix(1, 4), mA[6]);
    rdChk(ix(1, 5), mC[6]);
    rdChk(ix(1, 8), 'h04);
    serve(6);
    repeat (n + 1) adv(6, 1, 1);
    chk(nTc, xTc);
    // Demand verify runs to terminal count with no strobes
    setup(0, 0, 0, 0, 0, 0, a, 3);
    clr();
    serve(0);
    repeat (4) adv(0, 0, 0);
    chk(nAny, 0);
    chk(nTc, xTc);
    rdChk(ix(0, 0), mA[0]);
    // Cascade master keeps the bus while requesting
    setup(1, 3, 3, 0, 0, 0, a, 5);
    casc[7] <= 1'b1;
    clr();
    req[7] <= 1'b1;
    waitDack(7, 1'b1);
    repeat (8) @(posedge sys_clk);
    chk(dackOut, 'h80);
    chk(busAddrOe, 0);
    req[7] <= 1'b0;
    waitDack(7, 1'b0);
    chk(nAny, 0);
    rdChk(ix(1, 7), 5);
    test_done();
  end
endmodule
